/* File: core/smc_pkg.sv */
// standby mode control: shared constants, states and carrier types
// assumes a 100 MHz pclk and a 32-bit APB register bus
package smc_pkg;
   localparam int unsigned CLK_MHZ = 100;
   // oscillator settling wait after a stop pin release, in microseconds
   localparam int unsigned STAB_WAIT_US = 65000;
   localparam int unsigned STAB_WAIT_CYC = STAB_WAIT_US * CLK_MHZ;
   localparam int unsigned WAIT_W = 23;

   localparam logic [11:0] ADDR_TMODE = 12'h000;
   localparam logic [11:0] ADDR_TCMP = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_CTRL = 12'h00C;

   localparam logic [7:0] TMODE_RST = 8'hFF;
   localparam logic [7:0] TMODE_STOPPED = 8'hFF;
   localparam logic [7:0] TCMP_RST = 8'h00;
   localparam logic [7:0] TCNT_ZERO = 8'h00;
   localparam logic [15:0] VEC_NMI = 16'h0004;
   localparam logic [15:0] VEC_START = 16'h0000;

   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_SB = 3;
   localparam int unsigned ST_NMI = 4;
   localparam int unsigned ST_FT0 = 5;
   localparam int unsigned ST_FT1 = 6;
   localparam int unsigned ST_CNT_LSB = 8;
   localparam int unsigned CTRL_EXP = 0;

   typedef enum logic [2:0] {
      SMC_RUN = 3'b000,
      SMC_HALT = 3'b001,
      SMC_SSTOP = 3'b010,
      SMC_SWAIT = 3'b011,
      SMC_RESET = 3'b100,
      SMC_HSTOP = 3'b101,
      SMC_HWAIT = 3'b110
   } smc_state_t;

   typedef struct packed {
      logic halt_exec;
      logic stop_exec;
      logic sb_test;
      logic mcycle_end;
   } smc_cpu_req_t;

   typedef struct packed {
      logic vector_take;
      logic vector_nmi;
      logic resume_next;
      logic start_zero;
   } smc_cpu_resp_t;

   typedef struct packed {
      logic strobes_high;
      logic data_float;
      logic addr_hold;
      logic all_float;
   } smc_pin_ctl_t;
endpackage : smc_pkg

/* File: core/smc_itimer.sv */
// interval upcounter with compare match for the settling wait
// assumes run and clr come from the standby controller in the pclk domain
`timescale 1ns/1ps
`default_nettype none
module smc_itimer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic run,
   input wire logic [7:0] cmp,
   output logic [7:0] cnt,
   output logic match
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= smc_pkg::TCNT_ZERO;
      end else if (clr) begin
         cnt <= smc_pkg::TCNT_ZERO;
      end else if (run) begin
         if (cnt == cmp) begin
            cnt <= smc_pkg::TCNT_ZERO;
         end else begin
            cnt <= cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match <= 1'b0;
      end else begin
         match <= run && !clr && (cnt == cmp);
      end
   end
endmodule : smc_itimer
`default_nettype wire

/* File: core/smc_ctrl.sv */
// standby mode controller: halt, software stop, hardware stop, standby flag
// assumes pins and cpu strobes are synchronous to pclk, APB master on pclk
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl #(
   parameter int unsigned HW_WAIT_CYC = smc_pkg::STAB_WAIT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rst_pin_n,
   input wire logic stop_pin_n,
   input wire logic nmi_pin_n,
   input wire logic vdd_ok,
   input wire smc_pkg::smc_cpu_req_t cpu_req,
   input wire logic ie_state,
   input wire logic int_pend,
   input wire logic ext_int_pend,
   input wire logic tmr0_match,
   input wire logic nmi_ack,
   output smc_pkg::smc_cpu_resp_t cpu_resp,
   output logic [15:0] jump_addr,
   output logic core_clk_en,
   output logic core_reset,
   output logic osc_run,
   output logic nmi_req,
   output logic sb_flag,
   output smc_pkg::smc_pin_ctl_t pin_ctl
);
   smc_pkg::smc_state_t state_q, state_d;
   smc_pkg::smc_cpu_resp_t resp_d;
   logic [15:0] addr_d;
   logic rst_prev_q, stop_prev_q, nmi_prev_q, vdd_prev_q;
   logic rst_fall, rst_rise, stop_fall, stop_rise, nmi_fall;
   logic hs_pend_q, ft0_q, ft1_q, exp_q;
   logic [7:0] tmode_q, tcmp_q, tcnt;
   logic tmatch, t_run, t_clr, wait_done;
   logic [smc_pkg::WAIT_W-1:0] wait_q;
   logic wr_en, rd_en, hit;
   logic [31:0] rd_d;
   logic in_idle, in_stop;

   assign rst_fall = rst_prev_q && !rst_pin_n;
   assign rst_rise = !rst_prev_q && rst_pin_n;
   assign stop_fall = stop_prev_q && !stop_pin_n;
   assign stop_rise = !stop_prev_q && stop_pin_n;
   assign nmi_fall = nmi_prev_q && !nmi_pin_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_prev_q <= 1'b1;
         stop_prev_q <= 1'b1;
         nmi_prev_q <= 1'b1;
         vdd_prev_q <= 1'b0;
      end else begin
         rst_prev_q <= rst_pin_n;
         stop_prev_q <= stop_pin_n;
         nmi_prev_q <= nmi_pin_n;
         vdd_prev_q <= vdd_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_pend_q <= 1'b0;
      end else if (state_d == smc_pkg::SMC_HSTOP || stop_rise) begin
         hs_pend_q <= 1'b0;
      end else if (stop_fall) begin
         hs_pend_q <= 1'b1;
      end
   end

   assign wait_done = (wait_q == smc_pkg::WAIT_W'(HW_WAIT_CYC - 1));

   always_comb begin
      state_d = state_q;
      resp_d = '0;
      addr_d = jump_addr;
      case (state_q)
         smc_pkg::SMC_RUN: begin
            if (rst_fall) begin
               state_d = smc_pkg::SMC_RESET;
            end else if (hs_pend_q && cpu_req.mcycle_end) begin
               state_d = smc_pkg::SMC_HSTOP;
            end else if (cpu_req.halt_exec && !int_pend && !nmi_req) begin
               state_d = smc_pkg::SMC_HALT;
            end else if (cpu_req.stop_exec && !ext_int_pend) begin
               state_d = smc_pkg::SMC_SSTOP;
            end
         end
         smc_pkg::SMC_HALT: begin
            if (rst_fall) begin
               state_d = smc_pkg::SMC_RESET;
            end else if (hs_pend_q) begin
               state_d = smc_pkg::SMC_HSTOP;
            end else if (nmi_req) begin
               state_d = smc_pkg::SMC_RUN;
               resp_d.vector_take = 1'b1;
               resp_d.vector_nmi = 1'b1;
               addr_d = smc_pkg::VEC_NMI;
            end else if (int_pend) begin
               state_d = smc_pkg::SMC_RUN;
               resp_d.vector_take = ie_state;
               resp_d.resume_next = !ie_state;
            end
         end
         // only reset and nmi are watched
         smc_pkg::SMC_SSTOP: begin
            if (rst_fall) begin
               state_d = smc_pkg::SMC_RESET;
            end else if (nmi_fall) begin
               state_d = smc_pkg::SMC_SWAIT;
            end
         end
         smc_pkg::SMC_SWAIT: begin
            if (rst_fall) begin
               state_d = smc_pkg::SMC_RESET;
            end else if (tmatch) begin
               state_d = smc_pkg::SMC_RUN;
               resp_d.vector_take = 1'b1;
               resp_d.vector_nmi = 1'b1;
               addr_d = smc_pkg::VEC_NMI;
            end
         end
         smc_pkg::SMC_RESET: begin
            if (stop_fall || !stop_pin_n && !stop_prev_q && hs_pend_q) begin
               state_d = smc_pkg::SMC_HSTOP;
            end else if (rst_rise) begin
               state_d = smc_pkg::SMC_RUN;
               resp_d.start_zero = 1'b1;
               addr_d = smc_pkg::VEC_START;
            end
         end
         smc_pkg::SMC_HSTOP: begin
            if (stop_rise) begin
               state_d = rst_pin_n ? smc_pkg::SMC_HWAIT : smc_pkg::SMC_RESET;
            end
         end
         smc_pkg::SMC_HWAIT: begin
            if (rst_fall) begin
               state_d = smc_pkg::SMC_RESET;
            end else if (stop_fall) begin
               state_d = smc_pkg::SMC_HSTOP;
            end else if (wait_done) begin
               state_d = smc_pkg::SMC_RUN;
               resp_d.start_zero = 1'b1;
               addr_d = smc_pkg::VEC_START;
            end
         end
         default: begin
            state_d = smc_pkg::SMC_RESET;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= smc_pkg::SMC_RESET;
         cpu_resp <= '0;
         jump_addr <= smc_pkg::VEC_START;
      end else begin
         state_q <= state_d;
         cpu_resp <= resp_d;
         jump_addr <= addr_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= '0;
      end else if (state_q == smc_pkg::SMC_HWAIT && !wait_done) begin
         wait_q <= wait_q + 1'b1;
      end else if (state_q != smc_pkg::SMC_HWAIT) begin
         wait_q <= '0;
      end
   end

   assign in_idle = (state_d == smc_pkg::SMC_HALT) || in_stop;
   assign in_stop = (state_d == smc_pkg::SMC_SSTOP) || (state_d == smc_pkg::SMC_SWAIT);

   // outputs follow the state that is being entered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_clk_en <= 1'b0;
         core_reset <= 1'b1;
         osc_run <= 1'b1;
         pin_ctl <= '0;
      end else begin
         core_clk_en <= (state_d == smc_pkg::SMC_RUN);
         core_reset <= (state_d == smc_pkg::SMC_RESET) || (state_d == smc_pkg::SMC_HSTOP)
            || (state_d == smc_pkg::SMC_HWAIT);
         osc_run <= (state_d != smc_pkg::SMC_SSTOP) && (state_d != smc_pkg::SMC_HSTOP);
         pin_ctl.strobes_high <= in_idle;
         pin_ctl.data_float <= in_idle && exp_q;
         pin_ctl.addr_hold <= in_idle && exp_q;
         pin_ctl.all_float <= (state_d == smc_pkg::SMC_HSTOP)
            || (state_d == smc_pkg::SMC_HWAIT) || (state_d == smc_pkg::SMC_RESET);
      end
   end

   // nmi flag set on any nmi pin fall outside hardware stop, set beats ack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_req <= 1'b0;
      end else if (nmi_fall && state_q != smc_pkg::SMC_HSTOP) begin
         nmi_req <= 1'b1;
      end else if (nmi_ack) begin
         nmi_req <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sb_flag <= 1'b0;
      end else if (vdd_ok && !vdd_prev_q) begin
         sb_flag <= 1'b1;
      end else if (cpu_req.sb_test && state_q == smc_pkg::SMC_RUN) begin
         sb_flag <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ft0_q <= 1'b0;
         ft1_q <= 1'b0;
      end else if (state_d == smc_pkg::SMC_SSTOP && state_q != smc_pkg::SMC_SSTOP) begin
         ft0_q <= 1'b0;
         ft1_q <= 1'b0;
      end else begin
         if (tmr0_match && state_q != smc_pkg::SMC_SSTOP) begin
            ft0_q <= 1'b1;
         end
         // wake match leaves the flag alone
         // a match registered on the stop entry edge must not refill the flag
         if (tmatch && (state_q == smc_pkg::SMC_RUN || state_q == smc_pkg::SMC_HALT)) begin
            ft1_q <= 1'b1;
         end
      end
   end

   // timer keeps settings, counts from zero
   assign t_clr = (state_q == smc_pkg::SMC_SSTOP);
   assign t_run = (tmode_q != smc_pkg::TMODE_STOPPED) && ((state_q == smc_pkg::SMC_RUN)
      || (state_q == smc_pkg::SMC_HALT) || (state_q == smc_pkg::SMC_SWAIT));

   smc_itimer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .clr(t_clr),
      .run(t_run),
      .cmp(tcmp_q),
      .cnt(tcnt),
      .match(tmatch)
   );

   // zero wait states: every access ends in its first access cycle
   assign pready = 1'b1;
   assign hit = (paddr == smc_pkg::ADDR_TMODE) || (paddr == smc_pkg::ADDR_TCMP)
      || (paddr == smc_pkg::ADDR_STATUS) || (paddr == smc_pkg::ADDR_CTRL);
   assign pslverr = psel && penable && !hit;
   assign wr_en = psel && penable && pwrite && hit;
   assign rd_en = psel && !penable && !pwrite;

   // wake match forces the timer to stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmode_q <= smc_pkg::TMODE_RST;
      end else if (tmatch && state_q == smc_pkg::SMC_SWAIT) begin
         tmode_q <= smc_pkg::TMODE_STOPPED;
      end else if (wr_en && paddr == smc_pkg::ADDR_TMODE) begin
         tmode_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcmp_q <= smc_pkg::TCMP_RST;
         exp_q <= 1'b0;
      end else if (wr_en) begin
         if (paddr == smc_pkg::ADDR_TCMP) begin
            tcmp_q <= pwdata[7:0];
         end
         if (paddr == smc_pkg::ADDR_CTRL) begin
            exp_q <= pwdata[smc_pkg::CTRL_EXP];
         end
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      case (paddr)
         smc_pkg::ADDR_TMODE: rd_d[7:0] = tmode_q;
         smc_pkg::ADDR_TCMP: rd_d[7:0] = tcmp_q;
         smc_pkg::ADDR_STATUS: begin
            rd_d[smc_pkg::ST_STATE_LSB +: 3] = state_q;
            rd_d[smc_pkg::ST_SB] = sb_flag;
            rd_d[smc_pkg::ST_NMI] = nmi_req;
            rd_d[smc_pkg::ST_FT0] = ft0_q;
            rd_d[smc_pkg::ST_FT1] = ft1_q;
            rd_d[smc_pkg::ST_CNT_LSB +: 8] = tcnt;
         end
         smc_pkg::ADDR_CTRL: rd_d[smc_pkg::CTRL_EXP] = exp_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // read data captured in setup, steady through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= rd_d;
      end
   end

   chk_halt_vector: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_HALT && !rst_fall && !hs_pend_q && !nmi_req && int_pend
      && ie_state) |=> cpu_resp.vector_take && !cpu_resp.resume_next)
      else $error("halt wake with interrupts enabled did not vector");
   chk_halt_resume: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_HALT && !rst_fall && !hs_pend_q && !nmi_req && int_pend
      && !ie_state) |=> cpu_resp.resume_next && !cpu_resp.vector_take)
      else $error("halt wake with interrupts disabled did not resume");
   chk_stop_refused: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_RUN && cpu_req.stop_exec && ext_int_pend)
      |=> state_q != smc_pkg::SMC_SSTOP)
      else $error("stop entered with external request pending");
   chk_stop_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_q == smc_pkg::SMC_SSTOP) |-> !core_clk_en && !osc_run && !ft0_q && !ft1_q
      ##1 tcnt == smc_pkg::TCNT_ZERO)
      else $error("software stop left clocks or flags running");
   chk_stop_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_SSTOP && rst_fall) |=> state_q == smc_pkg::SMC_RESET
      && osc_run && core_reset)
      else $error("reset did not release software stop");
   chk_nmi_wake: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_SSTOP && !rst_fall && nmi_fall)
      |=> state_q == smc_pkg::SMC_SWAIT && nmi_req && osc_run)
      else $error("nmi did not release software stop");
   chk_match_start: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_SWAIT && !rst_fall && tmatch) |=> core_clk_en
      && tmode_q == smc_pkg::TMODE_STOPPED && !$rose(ft1_q))
      else $error("settling match did not start the cpu");
   chk_nmi_vector: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_SWAIT && !rst_fall && tmatch) |=> cpu_resp.vector_nmi
      && jump_addr == smc_pkg::VEC_NMI)
      else $error("wake from stop did not vector to nmi");
   chk_sb_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (cpu_req.sb_test && state_q == smc_pkg::SMC_RUN && !(vdd_ok && !vdd_prev_q))
      |=> !sb_flag)
      else $error("standby flag not cleared by test");
   chk_hstop_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_HSTOP && !stop_rise) |=> state_q == smc_pkg::SMC_HSTOP
      && pin_ctl.all_float)
      else $error("hardware stop left without stop pin rise");
   chk_wait_abandon: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == smc_pkg::SMC_HWAIT && rst_fall) |=> state_q == smc_pkg::SMC_RESET)
      else $error("reset did not abandon settling wait");
endmodule : smc_ctrl
`default_nettype wire

/* File: verification/smc_far_model.sv */
// far side model: reset, stop and nmi pin drivers plus a cpu core
// assumes the bench gives it pclk and calls its tasks
`timescale 1ns/1ps
`default_nettype none
module smc_far_model #(
   parameter int SETTLE = 24
) (
   input wire logic pclk,
   input wire logic core_clk_en,
   input wire smc_pkg::smc_cpu_resp_t cpu_resp,
   output logic rst_pin_n,
   output logic stop_pin_n,
   output logic nmi_pin_n,
   output smc_pkg::smc_cpu_req_t cpu_req,
   output logic nmi_ack
);
   logic [1:0] mc_q;
   initial begin
      stop_pin_n = 1'b1;
      rst_pin_n = 1'b1;
      nmi_pin_n = 1'b1;
      cpu_req = '0;
      nmi_ack = 1'b0;
      mc_q = 2'h0;
   end
   // machine cycle of four clocks; the core acks every nmi vector
   always @(posedge pclk) begin
      mc_q <= mc_q + 2'h1;
      cpu_req.mcycle_end <= core_clk_en && mc_q == 2'h3;
      nmi_ack <= cpu_resp.vector_nmi;
   end
   task automatic pin(input int k, input logic v);
      @(posedge pclk);
      case (k)
         0: rst_pin_n <= v;
         1: stop_pin_n <= v;
         default: nmi_pin_n <= v;
      endcase
   endtask : pin
   task automatic req(input int k);
      @(posedge pclk);
      cpu_req[k] <= 1'b1;
      @(posedge pclk);
      cpu_req[k] <= 1'b0;
   endtask : req
   task automatic rst_rel();
      repeat (SETTLE) @(posedge pclk);
      pin(0, 1'b1);
   endtask : rst_rel
   task automatic stop_low();
      repeat (SETTLE) @(posedge pclk);
      pin(1, 1'b0);
   endtask : stop_low
endmodule : smc_far_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the standby mode controller
// assumes smc_pkg, smc_ctrl and smc_far_model compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int HW = 20;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, r, rs = 32'h00016180;
   logic pready, pslverr, e, rst_pin_n, stop_pin_n, nmi_pin_n, nmi_ack;
   logic vdd_ok = 1'b0, ie_state = 1'b0, int_pend = 1'b0, ext_int_pend = 1'b0;
   logic tmr0_match = 1'b0, b;
   logic core_clk_en, core_reset, osc_run, nmi_req, sb_flag;
   logic [15:0] jump_addr;
   logic [7:0] t;
   smc_pkg::smc_cpu_req_t cpu_req;
   smc_pkg::smc_cpu_resp_t cpu_resp;
   smc_pkg::smc_pin_ctl_t pin_ctl;
   int n, fails = 0, checks_done = 0, cyc_q = 0;
   smc_ctrl #(.HW_WAIT_CYC(HW)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n),
      .stop_pin_n(stop_pin_n), .nmi_pin_n(nmi_pin_n), .vdd_ok(vdd_ok),
      .cpu_req(cpu_req), .ie_state(ie_state), .int_pend(int_pend),
      .ext_int_pend(ext_int_pend), .tmr0_match(tmr0_match), .nmi_ack(nmi_ack),
      .cpu_resp(cpu_resp), .jump_addr(jump_addr), .core_clk_en(core_clk_en),
      .core_reset(core_reset), .osc_run(osc_run), .nmi_req(nmi_req),
      .sb_flag(sb_flag), .pin_ctl(pin_ctl));
   smc_far_model #(.SETTLE(24)) far (.pclk(pclk), .core_clk_en(core_clk_en),
      .cpu_resp(cpu_resp), .rst_pin_n(rst_pin_n), .stop_pin_n(stop_pin_n),
      .nmi_pin_n(nmi_pin_n), .cpu_req(cpu_req), .nmi_ack(nmi_ack));
   always #5 pclk = ~pclk;
   // hang guard, well above the whole sequence
   always @(posedge pclk) begin
      cyc_q <= cyc_q + 1;
      if (cyc_q == 20000) begin
         fails = fails + 1;
         complete_run();
      end
   end
   function automatic logic [7:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs[7:0];
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is tied high, so this wait ends after one cycle
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic st(input logic [2:0] x);
      apb(1'b0, smc_pkg::ADDR_STATUS, 32'h0);
      chk("state", r[2:0], x);
   endtask : st
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask : cyc
   // bounded wait for one response pulse, cycles left in n
   task automatic wt(input int k);
      n = 0;
      while (cpu_resp[k] !== 1'b1 && n < 200) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("resp_wait", n < 200, 1'b1);
   endtask : wt
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, smc_pkg::ADDR_TMODE, 32'h0);
      chk("tmode_rst", r, 32'h000000FF);
      apb(1'b0, smc_pkg::ADDR_TCMP, 32'h0);
      chk("tcmp_rst", r, 32'h00000000);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", {r[30:0], e}, 32'h00000001);
      for (int i = 0; i < 4; i++) begin
         t = xs();
         apb(1'b1, smc_pkg::ADDR_TCMP, {24'h0, t});
         apb(1'b0, smc_pkg::ADDR_TCMP, 32'h0);
         chk("tcmp_rw", r, {24'h0, t});
      end
      apb(1'b1, smc_pkg::ADDR_STATUS, 32'hFFFFFFFF);
      st(3'h4);
      vdd_ok <= 1'b1;
      cyc(3);
      chk("sb_power_on", sb_flag, 1'b1);
      far.pin(0, 1'b0);
      far.rst_rel();
      wt(0);
      far.req(1);
      cyc(3);
      chk("sb_tested", sb_flag, 1'b0);
      // enable level drawn afresh at random on each pass, the second draw inverted, so both levels need not occur
      for (int i = 0; i < 2; i++) begin
         t = xs();
         b = t[0] ^ i[0];
         ie_state <= b;
         far.req(3);
         cyc(3);
         st(3'h1);
         int_pend <= 1'b1;
         ext_int_pend <= t[1];
         wt(b ? 3 : 1);
         chk("halt_vector", cpu_resp.vector_take, b);
         chk("halt_resume", cpu_resp.resume_next, !b);
         int_pend <= 1'b0;
         ext_int_pend <= 1'b0;
         st(3'h0);
      end
      ext_int_pend <= 1'b1;
      far.req(2);
      cyc(3);
      st(3'h0);
      ext_int_pend <= 1'b0;
      t = xs();
      b = t[0];
      tmr0_match <= b;
      cyc(1);
      tmr0_match <= 1'b0;
      apb(1'b0, smc_pkg::ADDR_STATUS, 32'h0);
      chk("ft0_rand", r[5], b);
      tmr0_match <= !b;
      cyc(1);
      tmr0_match <= 1'b0;
      t = xs();
      t = {4'h0, t[3:0]} + 8'h02;
      apb(1'b1, smc_pkg::ADDR_TCMP, {24'h0, t});
      apb(1'b1, smc_pkg::ADDR_TMODE, 32'h0);
      apb(1'b1, smc_pkg::ADDR_CTRL, 32'h00000001);
      apb(1'b0, smc_pkg::ADDR_STATUS, 32'h0);
      chk("ft0_set", r[5], 1'b1);
      far.req(2);
      cyc(3);
      st(3'h2);
      chk("ft_clear", r[6:5], 2'h0);
      chk("cnt_zero", r[15:8], smc_pkg::TCNT_ZERO);
      chk("clocks_off", {osc_run, core_clk_en}, 2'h0);
      chk("idle_pins", pin_ctl, 4'hE);
      far.pin(1, 1'b0);
      cyc(4);
      st(3'h2);
      far.pin(1, 1'b1);
      far.pin(2, 1'b0);
      cyc(3);
      chk("nmi_wake", {nmi_req, osc_run}, 2'h3);
      wt(2);
      chk("settle_len", n >= t, 1'b1);
      chk("nmi_vec", {cpu_resp.vector_take, jump_addr}, {1'b1, smc_pkg::VEC_NMI});
      far.pin(2, 1'b1);
      apb(1'b0, smc_pkg::ADDR_TMODE, 32'h0);
      chk("tmode_ff", r, 32'h000000FF);
      apb(1'b0, smc_pkg::ADDR_STATUS, 32'h0);
      chk("no_ft1", r[6], 1'b0);
      far.req(2);
      cyc(3);
      far.pin(0, 1'b0);
      cyc(3);
      st(3'h4);
      chk("osc_restart", osc_run, 1'b1);
      far.rst_rel();
      wt(0);
      chk("zero_addr", jump_addr, smc_pkg::VEC_START);
      chk("sb_standby", sb_flag, 1'b0);
      far.stop_low();
      cyc(8);
      st(3'h5);
      chk("hstop_pins", {pin_ctl.all_float, core_reset, osc_run}, 3'h6);
      far.pin(0, 1'b0);
      cyc(3);
      st(3'h5);
      far.pin(0, 1'b1);
      cyc(3);
      far.pin(1, 1'b1);
      wt(0);
      chk("hw_wait", n >= HW && n <= HW + 4, 1'b1);
      chk("hw_addr", jump_addr, smc_pkg::VEC_START);
      far.pin(0, 1'b0);
      far.stop_low();
      cyc(3);
      st(3'h5);
      far.pin(1, 1'b1);
      cyc(3);
      chk("osc_start", osc_run, 1'b1);
      far.pin(0, 1'b1);
      wt(0);
      chk("no_wait", n < 5, 1'b1);
      far.stop_low();
      cyc(8);
      far.pin(1, 1'b1);
      cyc(2);
      far.pin(0, 1'b0);
      cyc(3);
      far.pin(0, 1'b1);
      wt(0);
      chk("abandon_wait", n < 5, 1'b1);
      complete_run();
   end
endmodule : testbench
`default_nettype wire
